// ==== logic/dcc_comparator_ctrl.sv ====
// Control, status and change-detect logic around two analog comparators.
// Assumes raw comparator results arrive asynchronously from the analog side
// and software drives the register port synchronously on sys_clk.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

// Behaviour
// - Second comparator status bit shows raw result, swapped by its invert bit.
// - First comparator status bit shows raw result, swapped by its invert bit.
// - Two writable invert bits flip each comparator polarity; second sits higher.
// - In mode 110, input switch picks first or second pin for negatives.
// - Three-bit mode field in low bits selects one of eight modes.
// - Status bits are read-only; six control bits are read/write.
// - Raw result is high when positive input exceeds negative input.
// - Internal reference feeds both positive inputs only in mode 110.
// - Pin output path carries unsynchronized comparator result when enabled.
// - Port direction bits still gate the pin drivers.
// - Flag sets on any output change, and keeps setting while mismatched.
// - Software clears flag by writing 0; writing 1 sets it.
// - Request reaches processor only with all three enables; flag sets anyway.
// - Any control register read or write ends the mismatch condition.
// - Change coinciding with a control read may fail to set the flag.
// - Active comparator keeps running in sleep; enabled interrupt wakes device.
// - Mode 111 powers both comparators off.
// - Waking from sleep leaves the control register unchanged.
// - Reset returns control register to mode 000, pins analog, comparators off.
// - Port reads of analog-configured pins return 0.
module dcc_comparator_ctrl (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Analog side, asynchronous; bit 0 first comparator, bit 1 second
    input  wire logic [1:0] cmp_raw,
    input  wire logic [5:0] port_a_pins,
    output logic      [1:0] cmp_power_on,
    output logic            ref_to_pos,
    output logic            neg_sel_first,
    // Comparator output pins, direction low means driving
    output logic            cmp_a_out_pin,
    output logic            cmp_a_out_pin_oe_n,
    output logic            cmp_b_out_pin,
    output logic            cmp_b_out_pin_oe_n,
    // Interrupt request and sleep wake
    output logic            irq_req,
    output logic            wake_req
);

    logic [5:0] ctrl_r;        // Writable control bits 5:0
    logic [4:0] irq_r;         // Flag, enables, pin output enable
    logic [1:0] pdir_r;        // port_e_direction bits for the two pins
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [5:0] pin1_r;
    logic [5:0] pin2_r;
    logic [1:0] last_seen_r;   // Result value seen at last control access
    logic [1:0] status;
    logic       mismatch;
    logic       ctrl_access;
    logic [2:0] mode;
    logic [5:0] analog_mask;
    logic [7:0] rdata_nxt;

    assign mode        = ctrl_r[dcc_pkg::CTRL_MODE_LO +: 3];
    assign ctrl_access = (reg_wr || reg_rd) && (reg_addr == dcc_pkg::ADDR_CTRL);

    // Two-stage synchronizer per comparator result
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= cmp_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
            // Raw result is already high for plus above minus
            assign status[gi] = sync2_r[gi] ^ ctrl_r[dcc_pkg::CTRL_A_INV + gi];
        end
    endgenerate

    // Port pin synchronizer, digital read-back only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin1_r <= 6'h00;
            pin2_r <= 6'h00;
        end else begin
            pin1_r <= port_a_pins;
            pin2_r <= pin1_r;
        end
    end

    // Control register; status bits are never stored, so writes miss them
    // Only software writes or reset touch it, so a wake leaves it intact
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= dcc_pkg::CTRL_RESET[5:0];
        end else if (reg_wr && reg_addr == dcc_pkg::ADDR_CTRL) begin
            ctrl_r <= reg_wdata[5:0] & dcc_pkg::CTRL_WMASK[5:0];
        end
    end

    // Direction bits for the two output pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pdir_r <= dcc_pkg::PDIR_RESET;
        end else if (reg_wr && reg_addr == dcc_pkg::ADDR_PDIR) begin
            pdir_r <= reg_wdata[1:0];
        end
    end

    // Snapshot taken on any control access ends the mismatch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_seen_r <= 2'h0;
        end else if (ctrl_access) begin
            last_seen_r <= status;
        end
    end

    // A change landing in the access cycle is absorbed by the snapshot
    assign mismatch = (status != last_seen_r) && !ctrl_access;

    // Flag and enables; hardware set wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_r <= dcc_pkg::IRQ_RESET;
        end else begin
            if (reg_wr && reg_addr == dcc_pkg::ADDR_IRQ) begin
                irq_r <= reg_wdata[4:0];
            end
            if (mismatch) begin
                irq_r[dcc_pkg::IRQ_FLAG] <= 1'b1;
            end
        end
    end

    // Analog side controls follow the mode field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_power_on  <= 2'h0;
            ref_to_pos    <= 1'b0;
            neg_sel_first <= 1'b0;
        end else begin
            cmp_power_on  <= (mode == dcc_pkg::MODE_OFF || mode == dcc_pkg::MODE_RESET)
                             ? 2'h0 : 2'h3;
            ref_to_pos    <= (mode == dcc_pkg::MODE_MUX4);
            neg_sel_first <= (mode == dcc_pkg::MODE_MUX4) && ctrl_r[dcc_pkg::CTRL_ISW];
        end
    end

    // Request needs all three enables; wake needs only the comparator enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_req  <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req  <= irq_r[dcc_pkg::IRQ_FLAG] && irq_r[dcc_pkg::IRQ_CMP_EN]
                        && irq_r[dcc_pkg::IRQ_PER_EN] && irq_r[dcc_pkg::IRQ_GLB_EN];
            wake_req <= irq_r[dcc_pkg::IRQ_FLAG] && irq_r[dcc_pkg::IRQ_CMP_EN];
        end
    end

    // Pin path skips the synchronizer on purpose, so it is combinational
    always_comb begin
        if (irq_r[dcc_pkg::IRQ_PIN_EN]) begin
            cmp_a_out_pin = cmp_raw[0] ^ ctrl_r[dcc_pkg::CTRL_A_INV];
            cmp_b_out_pin = cmp_raw[1] ^ ctrl_r[dcc_pkg::CTRL_B_INV];
        end else begin
            cmp_a_out_pin = 1'b0;
            cmp_b_out_pin = 1'b0;
        end
    end
    assign cmp_a_out_pin_oe_n = pdir_r[0];
    assign cmp_b_out_pin_oe_n = pdir_r[1];

    // Comparator pins are analog in every mode except off
    assign analog_mask = (mode == dcc_pkg::MODE_OFF) ? 6'h00 : 6'h3f;

    // Read mux; unmapped space is impossible with two address bits
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            dcc_pkg::ADDR_CTRL: rdata_nxt = {status[1], status[0], ctrl_r};
            dcc_pkg::ADDR_IRQ:  rdata_nxt = {3'h0, irq_r};
            dcc_pkg::ADDR_PDIR: rdata_nxt = {6'h00, pdir_r};
            dcc_pkg::ADDR_PRD:  rdata_nxt = {2'h0, pin2_r & ~analog_mask};
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_B_STATUS: assert property (##1 reg_rd && reg_addr == dcc_pkg::ADDR_CTRL |=>
        reg_rdata[7] == ($past(sync2_r[1]) ^ $past(ctrl_r[5])))
        else $error("second status bit wrong");
    AST_A_STATUS: assert property (reg_rd && reg_addr == dcc_pkg::ADDR_CTRL |=>
        reg_rdata[6] == ($past(sync2_r[0]) ^ $past(ctrl_r[4])))
        else $error("first status bit wrong");
    AST_INV_PIN: assert property (irq_r[4] |->
        cmp_b_out_pin == (cmp_raw[1] ^ ctrl_r[5]))
        else $error("invert bit not applied to pin");
    AST_ISW: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[2:0] == 3'h6
        |=> ##1 neg_sel_first == $past(reg_wdata[3], 2))
        else $error("input switch not applied");
    AST_RO: assert property (reg_wr && reg_addr == 2'h0 |=>
        ctrl_r == $past(reg_wdata[5:0]))
        else $error("control write wrong");
    AST_REF: assert property (ref_to_pos |-> $past(mode) == dcc_pkg::MODE_MUX4)
        else $error("reference outside mux mode");
    AST_OE: assert property (cmp_a_out_pin_oe_n == pdir_r[0])
        else $error("direction not gating pin");
    AST_MISMATCH: assert property (mismatch |=> irq_r[0])
        else $error("flag not set on change");
    AST_CLEAR: assert property (reg_wr && reg_addr == 2'h1 && !reg_wdata[0] && !mismatch
        |=> !irq_r[0])
        else $error("flag not cleared");
    AST_REQ: assert property (irq_req |-> $past(irq_r[3:0]) == 4'hf)
        else $error("request without all enables");
    AST_ACCESS: assert property (ctrl_access |=> last_seen_r == $past(status))
        else $error("access did not end mismatch");
    AST_OFF: assert property (mode == dcc_pkg::MODE_OFF |=> cmp_power_on == 2'h0)
        else $error("off mode leaves power on");
    AST_SYNC: assert property (cmp_raw[0] [*3] |-> sync2_r[0])
        else $error("synchronizer lag wrong");

    COV_CHANGE: cover property (mismatch ##1 irq_req);
    COV_SWIRQ: cover property (reg_wr && reg_addr == 2'h1 && reg_wdata[0]);
    COV_MUX4: cover property (ref_to_pos && neg_sel_first);
    COV_PINOUT: cover property (irq_r[4] && !cmp_a_out_pin_oe_n);

endmodule

// ==== logic/dcc_pkg.sv ====
// Constants for the dual comparator control block.
// Assumes a byte-wide register port with small word addresses.
package dcc_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_CTRL = 2'h0; // comparator_control
    localparam logic [1:0] ADDR_IRQ  = 2'h1; // Flag and enable chain
    localparam logic [1:0] ADDR_PDIR = 2'h2; // port_e_direction for output pins
    localparam logic [1:0] ADDR_PRD  = 2'h3; // port_a pin read-back

    // comparator_control field positions
    localparam int CTRL_B_RESULT = 7;
    localparam int CTRL_A_RESULT = 6;
    localparam int CTRL_B_INV    = 5;
    localparam int CTRL_A_INV    = 4;
    localparam int CTRL_ISW      = 3;
    localparam int CTRL_MODE_LO  = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h3f;

    // Flag and enable register field positions
    localparam int IRQ_FLAG   = 0;
    localparam int IRQ_CMP_EN = 1;
    localparam int IRQ_PER_EN = 2;
    localparam int IRQ_GLB_EN = 3;
    localparam int IRQ_PIN_EN = 4;
    localparam logic [4:0] IRQ_RESET = 5'h00;

    // Direction bits reset to input, pins undriven
    localparam logic [1:0] PDIR_RESET = 2'h3;

    // Mode field encodings
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_MUX4  = 3'h6;
    localparam logic [2:0] MODE_OFF   = 3'h7;
endpackage

// ==== verification/dcc_analog_model.sv ====
// Behavioural analog side: two comparators and the port pin levels.
// Assumes the bench drives plain unsigned level codes on both inputs.
`timescale 1ns/1ns
module dcc_analog_model (
    // Levels, low byte for the first comparator
    input  wire logic [15:0] pos_lvl,
    input  wire logic [15:0] neg_lvl,
    // Digital view of the analog side
    output logic      [1:0]  cmp_raw,
    output logic      [5:0]  port_a_pins
);
    // High only when plus is strictly above minus; a tie reads low
    assign cmp_raw[0] = pos_lvl[7:0] > neg_lvl[7:0];
    assign cmp_raw[1] = pos_lvl[15:8] > neg_lvl[15:8];
    // Fixed pattern so digital read-back is predictable
    assign port_a_pins = 6'h2a;
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the dual comparator control block.
// Assumes the analog model and the design package are compiled first.
`timescale 1ns/1ns
module tb_top;
    logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic [1:0] reg_addr = 2'h0, cmp_raw, pwr;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_q[$];
    logic [5:0] port_a_pins;
    logic       ref_pos, nsel, pin_a, oe_a, pin_b, oe_b, irq_req, wake_req;
    logic [15:0] pos_lvl = 16'h0000, neg_lvl = 16'h8080;
    int         num_errors = 0, comparisons = 0, seed = 32'hd60c;

    always #50 sys_clk = ~sys_clk;

    dcc_analog_model u_ana (.pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .cmp_raw(cmp_raw),
        .port_a_pins(port_a_pins));
    dcc_comparator_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_raw(cmp_raw), .port_a_pins(port_a_pins), .cmp_power_on(pwr),
        .ref_to_pos(ref_pos), .neg_sel_first(nsel), .cmp_a_out_pin(pin_a),
        .cmp_a_out_pin_oe_n(oe_a), .cmp_b_out_pin(pin_b), .cmp_b_out_pin_oe_n(oe_b),
        .irq_req(irq_req), .wake_req(wake_req));

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        comparisons++;
        if (seen !== expv) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Gap cycle after each strobe keeps a driver from assigning twice per step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    // Raw to flag takes three edges, to request four
    task automatic settle();
        repeat (5) @(posedge sys_clk);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen) begin
            if (exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
            else num_errors++;
        end
        rd_seen <= reg_rd;
    end

    initial begin
        logic [7:0] d;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset state
        rd(dcc_pkg::ADDR_CTRL, 8'h00);
        rd(dcc_pkg::ADDR_IRQ, 8'h00);
        rd(dcc_pkg::ADDR_PDIR, 8'h03);
        rd(dcc_pkg::ADDR_PRD, 8'h00);
        check({6'h0, oe_b, oe_a}, 8'h03);
        // Status bits ignore writes; inversion flips them
        wr(dcc_pkg::ADDR_CTRL, 8'hff);
        settle();
        rd(dcc_pkg::ADDR_CTRL, 8'hff);
        rd(dcc_pkg::ADDR_PRD, 8'h2a);
        // Every mode, interrupts still disabled while switching
        for (int m = 0; m < 8; m++) begin
            wr(dcc_pkg::ADDR_CTRL, 8'(m));
            settle();
            check({6'h0, pwr}, (m == 0 || m == 7) ? 8'h00 : 8'h03);
            check({7'h0, ref_pos}, {7'h0, m == 6});
        end
        wr(dcc_pkg::ADDR_CTRL, 8'h0e);
        settle();
        check({7'h0, nsel}, 8'h01);
        // Change detect, persistence and the enable chain
        wr(dcc_pkg::ADDR_CTRL, 8'h02);
        wr(dcc_pkg::ADDR_IRQ, 8'h0e);
        rd(dcc_pkg::ADDR_CTRL, 8'h02);
        wr(dcc_pkg::ADDR_IRQ, 8'h0e);
        rd(dcc_pkg::ADDR_IRQ, 8'h0e);
        pos_lvl <= 16'h00ff;
        settle();
        rd(dcc_pkg::ADDR_IRQ, 8'h0f);
        check({6'h0, irq_req, wake_req}, 8'h03);
        wr(dcc_pkg::ADDR_IRQ, 8'h0e);
        settle();
        rd(dcc_pkg::ADDR_IRQ, 8'h0f);
        rd(dcc_pkg::ADDR_CTRL, 8'h42);
        wr(dcc_pkg::ADDR_IRQ, 8'h0e);
        settle();
        rd(dcc_pkg::ADDR_IRQ, 8'h0e);
        check({7'h0, irq_req}, 8'h00);
        wr(dcc_pkg::ADDR_IRQ, 8'h07);
        settle();
        rd(dcc_pkg::ADDR_IRQ, 8'h07);
        check({6'h0, irq_req, wake_req}, 8'h01);
        // Pin path follows the raw result without synchronisation
        wr(dcc_pkg::ADDR_IRQ, 8'h10);
        wr(dcc_pkg::ADDR_PDIR, 8'h00);
        settle();
        check({5'h0, oe_b, oe_a, pin_a}, 8'h01);
        @(posedge sys_clk);
        pos_lvl <= 16'h0000;
        #1 check({7'h0, pin_a}, 8'h00);
        wr(dcc_pkg::ADDR_CTRL, 8'h30);
        settle();
        check({6'h0, pin_b, pin_a}, 8'h03);
        rd(dcc_pkg::ADDR_CTRL, 8'hf0);
        // Random control values against random levels
        repeat (8) begin
            d = 8'($random(seed));
            pos_lvl <= 16'($random(seed));
            wr(dcc_pkg::ADDR_CTRL, d);
            settle();
            rd(dcc_pkg::ADDR_CTRL, {(pos_lvl[15:8] > 8'h80) ^ d[5],
                (pos_lvl[7:0] > 8'h80) ^ d[4], d[5:0]});
        end
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge sys_clk);
        if (exp_q.size() > 0) num_errors++;
        conclude();
    end
endmodule
